// ### rtl/adc_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "adc_link_defines.svh"

module adc_host (
  input  wire logic                      clock,      // System clock
  input  wire logic                      rst_b,      // Async reset, low
  adc_link_if.host                       link,       // Serial link pins
  input  wire logic                      sync_req,   // Pulse in H_WAIT: issue sync
  input  wire logic                      cs_mode,    // 1: select per read
  output logic                           word_valid, // Word available
  input  wire logic                      word_ready, // User accepts word
  output logic [`ADC_WORD_BITS-1:0]      word_data   // Received word
);

  // ----------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------
  localparam logic [7:0] MCLK_LAST = 8'(`HOST_MCLK_HALF - 1);
  localparam logic [7:0] SCLK_LAST = 8'(`HOST_SCLK_HALF - 1);
  localparam logic [7:0] SYNC_LAST = 8'(`HOST_SYNC_CYC - 1);
  localparam logic [4:0] BITS      = 5'(`ADC_WORD_BITS);
  localparam logic [3:0] WORD_LAST = 4'(`ADC_CHAIN - 1);

  // ----------------------------------------------------------------
  // Master clock divider, free running from reset
  // ----------------------------------------------------------------
  logic [7:0] mclk_cnt;
  logic       mclk;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mclk_cnt <= 8'h00;
      mclk     <= 1'b0;
    end else if (mclk_cnt == MCLK_LAST) begin
      mclk_cnt <= 8'h00;
      mclk     <= ~mclk;                                 // [RULE11]
    end else begin
      mclk_cnt <= mclk_cnt + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] pin_raw;
  logic [1:0] pin_meta;
  logic [1:0] pin_s;
  logic       ready_prev;
  logic       ready_fall;

  assign pin_raw = {link.ready_n, link.sdo_line};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_sync
      always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
          pin_meta[g] <= 1'b1;
          pin_s[g]    <= 1'b1;
        end else begin
          pin_meta[g] <= pin_raw[g];
          pin_s[g]    <= pin_meta[g];
        end
      end
    end
  endgenerate

  assign ready_fall = ready_prev & ~pin_s[1];

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ready_prev <= 1'b1;
    end else begin
      ready_prev <= pin_s[1];
    end
  end

  // ----------------------------------------------------------------
  // Read sequencer
  // ----------------------------------------------------------------
  adc_link_pkg::host_state_e  state;
  adc_link_pkg::host_state_e  next_state;
  logic [7:0]                 cnt;
  logic [7:0]                 next_cnt;
  logic [4:0]                 bit_cnt;
  logic [4:0]                 next_bits;
  logic [3:0]                 word_cnt;
  logic [3:0]                 next_words;
  logic [`ADC_WORD_BITS-1:0]  word;
  logic [`ADC_WORD_BITS-1:0]  next_word;
  logic                       sclk;
  logic                       next_sclk;
  logic                       cs_reg;
  logic                       next_cs;
  logic                       buf_in_ready;
  logic                       push;
  logic                       half_done;

  assign half_done = (cnt == SCLK_LAST);
  assign push      = (state == adc_link_pkg::H_PUSH);

  // Next-state decode
  always_comb begin
    next_state = state;
    next_cnt   = cnt + 8'h01;
    next_bits  = bit_cnt;
    next_words = word_cnt;
    next_word  = word;
    next_sclk  = sclk;
    next_cs    = cs_reg;
    case (state)
      adc_link_pkg::H_SYNC: begin
        if (cnt == SYNC_LAST) begin                      // [RULE14]
          next_state = adc_link_pkg::H_WAIT;
          next_cnt   = 8'h00;
        end
      end
      adc_link_pkg::H_WAIT: begin
        next_cnt = 8'h00;
        if (sync_req) begin
          next_state = adc_link_pkg::H_SYNC;
        end else if (ready_fall && buf_in_ready) begin   // [RULE3] [RULE20]
          next_state = adc_link_pkg::H_SETUP;
          next_cs    = 1'b0;
          next_bits  = 5'h00;
          next_words = 4'h0;
        end
      end
      adc_link_pkg::H_SETUP: begin
        if (half_done) begin
          next_state = adc_link_pkg::H_HIGH;
          next_cnt   = 8'h00;
        end
      end
      adc_link_pkg::H_HIGH: begin
        if (half_done) begin                             // [RULE17] [RULE18]
          next_word  = {word[`ADC_WORD_BITS-2:0], pin_s[0]};
          next_sclk  = 1'b0;
          next_bits  = bit_cnt + 5'h01;
          next_state = adc_link_pkg::H_LOW;
          next_cnt   = 8'h00;
        end
      end
      adc_link_pkg::H_LOW: begin
        if (half_done) begin
          next_sclk  = 1'b1;
          next_cnt   = 8'h00;
          next_state = (bit_cnt == BITS) ? adc_link_pkg::H_PUSH
                                         : adc_link_pkg::H_HIGH; // [RULE16]
        end
      end
      adc_link_pkg::H_PUSH: begin
        next_cnt = 8'h00;
        if (buf_in_ready) begin
          next_bits  = 5'h00;
          next_words = word_cnt + 4'h1;
          next_state = (word_cnt == WORD_LAST) ? adc_link_pkg::H_END
                                               : adc_link_pkg::H_HIGH;
        end
      end
      adc_link_pkg::H_END: begin
        next_cs    = 1'b1;
        next_state = adc_link_pkg::H_WAIT;
      end
      default: begin
        next_state = adc_link_pkg::H_WAIT;
      end
    endcase
  end

  // Sequencer registers; a sync pulse starts after reset
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state    <= adc_link_pkg::H_SYNC;                  // [RULE11]
      cnt      <= 8'h00;
      bit_cnt  <= 5'h00;
      word_cnt <= 4'h0;
      word     <= '0;
      sclk     <= 1'b1;
      cs_reg   <= 1'b1;
    end else begin
      state    <= next_state;
      cnt      <= next_cnt;
      bit_cnt  <= next_bits;
      word_cnt <= next_words;
      word     <= next_word;
      sclk     <= next_sclk;
      cs_reg   <= next_cs;
    end
  end

  // Pin drive; 3-wire mode holds select low
  assign link.mclk   = mclk;
  assign link.sclk   = sclk;
  assign link.cs_n   = cs_mode ? cs_reg : 1'b0;
  assign link.sync_n = (state != adc_link_pkg::H_SYNC);  // [RULE14]
  assign link.sdi    = `ADC_SDI_GROUND;                  // [RULE13]

  // ----------------------------------------------------------------
  // Result buffer toward the user
  // ----------------------------------------------------------------
  pair_buffer #(
    .WIDTH (`ADC_WORD_BITS)
  ) u_buf (
    .clock     (clock),
    .rst_b     (rst_b),
    .in_valid  (push),
    .in_ready  (buf_in_ready),
    .in_data   (word),
    .out_valid (word_valid),
    .out_ready (word_ready),
    .out_data  (word_data)
  );

endmodule

`default_nettype wire

// ### rtl/adc_link_defines.svh
`ifndef ADC_LINK_DEFINES_SVH
`define ADC_LINK_DEFINES_SVH

// ----------------------------------------------------------------
// Word format and conversion timing
// ----------------------------------------------------------------
`define ADC_WORD_BITS   24
`define ADC_DECIM       8
`define ADC_SETTLE_D8   594
`define ADC_SETTLE_D16  1186
`define ADC_SETTLE_D32  2370
`define ADC_SETTLE_MCLK `ADC_SETTLE_D8
`define ADC_SETTLE_W    12

// ----------------------------------------------------------------
// System clock and derived cycle counts
// ----------------------------------------------------------------
`define ADC_CLK_NS      25
`define ADC_FIX_NS      100
`define ADC_FIX_CYC     ((`ADC_FIX_NS + `ADC_CLK_NS - 1) / `ADC_CLK_NS)
`define ADC_PIN_IDLE    5'h0E

// ----------------------------------------------------------------
// Host link timing
// ----------------------------------------------------------------
`define HOST_MCLK_NS    2000
`define HOST_MCLK_HALF  (`HOST_MCLK_NS / 2 / `ADC_CLK_NS)
`define HOST_SCLK_NS    400
`define HOST_SCLK_HALF  (`HOST_SCLK_NS / 2 / `ADC_CLK_NS)
`define HOST_SYNC_MCLK  2
`define HOST_SYNC_CYC   (`HOST_SYNC_MCLK * `HOST_MCLK_NS / `ADC_CLK_NS)
`define ADC_CHAIN       1
`define ADC_SDI_GROUND  1'h0

`endif

// ### rtl/adc_link_pkg.sv
`default_nettype none

package adc_link_pkg;

  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DEV_PD,
    DEV_EXIT,
    DEV_FRESET,
    DEV_SETTLE,
    DEV_RUN
  } dev_state_e;

  typedef enum logic [2:0] {
    H_SYNC,
    H_WAIT,
    H_SETUP,
    H_HIGH,
    H_LOW,
    H_PUSH,
    H_END
  } host_state_e;

endpackage

`default_nettype wire

// ### rtl/adc_link_if.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Serial link between converter and host
// ----------------------------------------------------------------
interface adc_link_if;
  logic mclk;      // Master clock
  logic sclk;      // Serial clock
  logic cs_n;      // Chip select
  logic sync_n;    // Sync / power-down
  logic sdi;       // Chain data input
  logic ready_n;   // Result ready
  logic sdo;       // Serial data value
  logic sdo_oe;    // Serial data enable
  wire  sdo_line;  // Serial data as the host sees it

  // Released line shows the inverse bit, so early sampling is caught
  assign sdo_line = sdo_oe ? sdo : ~sdo;

  modport device (
    input  mclk, sclk, cs_n, sync_n, sdi,
    output ready_n, sdo, sdo_oe
  );
  modport host (
    output mclk, sclk, cs_n, sync_n, sdi,
    input  ready_n, sdo_line
  );
endinterface

`default_nettype wire

// ### rtl/pair_buffer.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Two-entry buffer with valid/ready on both sides
// ----------------------------------------------------------------
module pair_buffer #(
  parameter int WIDTH = 24
) (
  input  wire logic             clock,     // System clock
  input  wire logic             rst_b,     // Async reset, active low
  input  wire logic             in_valid,  // Write request
  output logic                  in_ready,  // Space available
  input  wire logic [WIDTH-1:0] in_data,   // Write data
  output logic                  out_valid, // Data available
  input  wire logic             out_ready, // Reader accepts
  output logic      [WIDTH-1:0] out_data   // Read data
);
  logic [WIDTH-1:0] mem [2];
  logic             wr_ptr;
  logic             rd_ptr;
  logic [1:0]       count;
  logic             do_wr;
  logic             do_rd;

  // Honest full and empty
  assign in_ready  = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign do_wr     = in_valid & in_ready;
  assign do_rd     = out_valid & out_ready;
  assign out_data  = mem[rd_ptr];

  // Storage write
  always_ff @(posedge clock) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end else begin
      wr_ptr <= wr_ptr ^ do_wr;
      rd_ptr <= rd_ptr ^ do_rd;
      count  <= count + {1'b0, do_wr} - {1'b0, do_rd};
    end
  end
endmodule

`default_nettype wire

// ### rtl/adc_device.sv
`timescale 1ns/1ps
`default_nettype none
`include "adc_link_defines.svh"

// How it works
// [RULE1] Result is 24-bit twos complement, MSB first
// [RULE2] Ready low when word held, high updating
// [RULE3] Host never reads while ready is high
// [RULE4] Data output released while chip select high
// [RULE5] Late chip select: MSB at select fall
// [RULE6] Select held low: MSB at ready fall
// [RULE7] Sync low on master edge powers down
// [RULE8] Exit, filter reset, sample on edges 1-3
// [RULE9] Ready falls after settle count plus delay
// [RULE10] Sync pulse resets; ready high until valid
// [RULE11] Host runs master clock, then syncs
// [RULE12] Chain input shifts through on serial falls
// [RULE13] Last chain input grounded, lines shared
// [RULE14] One common sync pulse before chain read
// [RULE15] Chain carries words in order, MSB first
// [RULE16] Host gives 24 serial falls per device
// [RULE17] Serial period fits read window, 3-wire
// [RULE18] Serial period fits window less select delays
// [RULE19] One word per eight master clocks
// [RULE20] Host ignores data before first ready fall
module adc_device (
  input  wire logic                      clock,        // System clock
  input  wire logic                      rst_b,        // Async reset, low
  adc_link_if.device                     link,         // Serial link pins
  input  wire logic [`ADC_WORD_BITS-1:0] sample_word,  // Filtered result
  output logic                           powered_down, // In power-down
  output logic                           sample_taken  // Pulse per sample
);

  // ----------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------
  localparam int NPIN = 5;
  localparam logic [NPIN-1:0] PIN_IDLE = `ADC_PIN_IDLE;
  localparam logic [2:0] DEC_LAST = 3'(`ADC_DECIM - 1);
  localparam logic [2:0] DEC_UPD  = 3'(`ADC_DECIM - 2);
  localparam logic [`ADC_SETTLE_W-1:0] SETTLE_LAST =
    `ADC_SETTLE_W'(`ADC_SETTLE_MCLK - 1);
  localparam logic [3:0] FIX_CYC  = 4'(`ADC_FIX_CYC);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_meta;
  logic [NPIN-1:0] pin_s;

  assign pin_raw = {link.mclk, link.sclk, link.cs_n, link.sync_n, link.sdi};

  // Two flops per pin before any logic
  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : g_sync
      always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
          pin_meta[g] <= PIN_IDLE[g];
          pin_s[g]    <= PIN_IDLE[g];
        end else begin
          pin_meta[g] <= pin_raw[g];
          pin_s[g]    <= pin_meta[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  logic mclk_prev;
  logic sclk_prev;
  logic mclk_rise;
  logic sclk_fall;
  logic cs_low;
  logic sync_high;
  logic sdi_s;

  // Decoded pin events
  assign mclk_rise = pin_s[4] & ~mclk_prev;
  assign sclk_fall = ~pin_s[3] & sclk_prev;
  assign cs_low    = ~pin_s[2];
  assign sync_high = pin_s[1];
  assign sdi_s     = pin_s[0];

  // Previous clock levels
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mclk_prev <= 1'b0;
      sclk_prev <= 1'b1;
    end else begin
      mclk_prev <= pin_s[4];
      sclk_prev <= pin_s[3];
    end
  end

  // ----------------------------------------------------------------
  // Sequencer: power-down, settling and word rate
  // ----------------------------------------------------------------
  adc_link_pkg::dev_state_e   state;
  adc_link_pkg::dev_state_e   next_state;
  logic [`ADC_SETTLE_W-1:0]   settle_cnt;
  logic [`ADC_SETTLE_W-1:0]   next_settle;
  logic [2:0]                 dec_cnt;
  logic [2:0]                 next_dec;
  logic [3:0]                 fix_cnt;
  logic [3:0]                 next_fix;
  logic                       start_load;
  logic                       mark_update;
  logic                       enter_pd;
  logic                       load_now;

  assign enter_pd = mclk_rise & ~sync_high;              // [RULE7]
  assign load_now = (fix_cnt == 4'h1);

  // Next-state decode on master clock rising edges
  always_comb begin
    next_state  = state;
    next_settle = settle_cnt;
    next_dec    = dec_cnt;
    start_load  = 1'b0;
    mark_update = 1'b0;
    if (enter_pd) begin
      next_state = adc_link_pkg::DEV_PD;                 // [RULE7] [RULE10]
    end else if (mclk_rise) begin
      case (state)
        adc_link_pkg::DEV_PD: begin
          next_state  = adc_link_pkg::DEV_EXIT;          // [RULE8]
          next_settle = '0;                              // [RULE9]
        end
        adc_link_pkg::DEV_EXIT: begin
          next_state  = adc_link_pkg::DEV_FRESET;        // [RULE8]
          next_settle = settle_cnt + 1'b1;
        end
        adc_link_pkg::DEV_FRESET: begin
          next_state  = adc_link_pkg::DEV_SETTLE;        // [RULE8]
          next_settle = settle_cnt + 1'b1;
        end
        adc_link_pkg::DEV_SETTLE: begin
          next_settle = settle_cnt + 1'b1;
          if (settle_cnt == SETTLE_LAST) begin           // [RULE9]
            next_state = adc_link_pkg::DEV_RUN;
            next_dec   = 3'h0;
            start_load = 1'b1;
          end
        end
        adc_link_pkg::DEV_RUN: begin
          next_dec = dec_cnt + 1'b1;                     // [RULE19]
          if (dec_cnt == DEC_UPD) begin
            mark_update = 1'b1;                          // [RULE2]
          end
          if (dec_cnt == DEC_LAST) begin
            start_load = 1'b1;                           // [RULE19]
          end
        end
        default: begin
          next_state = adc_link_pkg::DEV_PD;
        end
      endcase
    end
  end

  // Fixed delay from load edge to ready fall
  always_comb begin
    next_fix = fix_cnt;
    if (enter_pd) begin
      next_fix = 4'h0;
    end else if (start_load) begin
      next_fix = FIX_CYC;                                // [RULE9]
    end else if (fix_cnt != 4'h0) begin
      next_fix = fix_cnt - 4'h1;
    end
  end

  // Sequencer registers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state      <= adc_link_pkg::DEV_PD;
      settle_cnt <= '0;
      dec_cnt    <= 3'h0;
      fix_cnt    <= 4'h0;
    end else begin
      state      <= next_state;
      settle_cnt <= next_settle;
      dec_cnt    <= next_dec;
      fix_cnt    <= next_fix;
    end
  end

  // ----------------------------------------------------------------
  // Ready flag and status outputs
  // ----------------------------------------------------------------
  logic ready_n;
  logic sample_edge;

  // Third edge after sync rise and every edge after it
  assign sample_edge = mclk_rise & sync_high &
                       (state == adc_link_pkg::DEV_FRESET ||
                        state == adc_link_pkg::DEV_SETTLE ||
                        state == adc_link_pkg::DEV_RUN);

  // Ready high on power-down and update, low on load
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ready_n      <= 1'b1;
      powered_down <= 1'b1;
      sample_taken <= 1'b0;
    end else begin
      if (enter_pd || mark_update) begin
        ready_n <= 1'b1;                                 // [RULE2] [RULE10]
      end else if (load_now) begin
        ready_n <= 1'b0;                                 // [RULE2] [RULE9]
      end
      powered_down <= (next_state == adc_link_pkg::DEV_PD);
      sample_taken <= sample_edge;                       // [RULE8]
    end
  end

  assign link.ready_n = ready_n;

  // ----------------------------------------------------------------
  // Output shift register
  // ----------------------------------------------------------------
  logic [`ADC_WORD_BITS-1:0] shreg;

  // Load on ready fall, shift chain data on serial falls
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      shreg <= '0;
    end else if (load_now) begin
      shreg <= sample_word;                              // [RULE1] [RULE6]
    end else if (sclk_fall && cs_low) begin
      shreg <= {shreg[`ADC_WORD_BITS-2:0], sdi_s};       // [RULE12] [RULE15]
    end
  end

  // MSB drives the line while selected
  assign link.sdo    = shreg[`ADC_WORD_BITS-1];          // [RULE1] [RULE5]
  assign link.sdo_oe = cs_low;                           // [RULE4]

endmodule

`default_nettype wire

// ### verif/adc_link_asserts.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Link checker
// ----------------------------------------------------------------
module adc_link_asserts (
  input wire logic clock,   // System clock
  input wire logic rst_b,   // Async reset
  input wire logic sclk,    // Serial clock
  input wire logic cs_n,    // Chip select
  input wire logic sync_n,  // Sync pin
  input wire logic ready_n, // Result ready
  input wire logic sdo_oe,  // Data enable
  input wire logic sdo      // Serial data bit
);
  logic        rdy_q;
  logic        sclk_q;
  logic        first;
  logic        gap_ok;
  logic [15:0] gap;
  logic [15:0] since;
  logic [7:0]  low;
  logic [7:0]  fcnt;
  wire         fall_r = rdy_q & ~ready_n;
  wire         rise_r = ready_n & ~rdy_q;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);

  // Edge history and first-word flag
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rdy_q  <= 1'b1;
      sclk_q <= 1'b1;
      first  <= 1'b1;
    end else begin
      rdy_q  <= ready_n;
      sclk_q <= sclk;
      first  <= !sync_n | (first & ~fall_r);
    end
  end

  // Cycle counters for settle, word rate, sync low and serial falls
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      gap    <= '0;
      gap_ok <= 1'b0;
      since  <= '0;
      low    <= '0;
      fcnt   <= '0;
    end else begin
      gap    <= fall_r ? 16'h0001 : gap + 16'h0001;
      gap_ok <= sync_n & (gap_ok | fall_r);
      since  <= !sync_n ? '0 : since + {15'h0000, ~&since};
      low    <= sync_n ? '0 : low + {7'h00, ~&low};
      fcnt   <= fall_r ? '0 : fcnt + {7'h00, sclk_q & ~sclk};
    end
  end

  property p_release; cs_n [*4] |-> !sdo_oe; endproperty
  a_release: assert property (p_release)
    else $error("data line driven while deselected");
  property p_enable; (!cs_n) [*4] |-> sdo_oe; endproperty
  a_enable: assert property (p_enable)
    else $error("data line not driven while selected");
  property p_window; $fell(sclk) |-> !ready_n && sdo_oe; endproperty
  a_window: assert property (p_window)
    else $error("serial fall outside read window");
  property p_pd_ready; low > 8'h5A |-> ready_n; endproperty
  a_pd_ready: assert property (p_pd_ready)
    else $error("ready low during power-down");
  property p_settle; fall_r && first |-> since inside {[47500:47640]};
  endproperty
  a_settle: assert property (p_settle)
    else $error("first ready fall off settle time");
  property p_rate; fall_r && gap_ok |-> gap inside {[638:642]}; endproperty
  a_rate: assert property (p_rate)
    else $error("word period not eight master clocks");
  property p_low_hold; $fell(ready_n) |=> (!ready_n) [*8]; endproperty
  a_low_hold: assert property (p_low_hold)
    else $error("ready low too short");
  property p_bits; rise_r && gap_ok |-> fcnt == 8'h00 || fcnt == 8'h18;
  endproperty
  a_bits: assert property (p_bits)
    else $error("serial fall count per window wrong");
  property p_hold_pd; first && sync_n && !fall_r |-> ready_n; endproperty
  a_hold_pd: assert property (p_hold_pd)
    else $error("ready low before valid data");
  property p_chain; fcnt == 8'h18 && !ready_n && !fall_r |-> ##2 !sdo;
  endproperty
  a_chain: assert property (p_chain)
    else $error("grounded chain input not shifted through");

  c_fall: cover property (fall_r);
  c_select: cover property ($fell(cs_n));
  c_pd: cover property (low > 8'h5A);
endmodule

`default_nettype wire

// ### verif/adc_link_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "adc_link_defines.svh"

// ----------------------------------------------------------------
// Link bench
// ----------------------------------------------------------------
module adc_link_tb;
  logic        clock = 1'b0;
  logic        rst_b = 1'b0;
  logic [23:0] sample_word;
  logic        sync_req;
  logic        cs_mode;
  logic        word_ready;
  logic        word_valid;
  logic [23:0] word_data;
  logic        powered_down;
  logic        sample_taken;
  int          err_count;
  int          checks_done;
  int          cycles;
  int          n;

  adc_link_if link();
  adc_device i_adc_device (.clock(clock), .rst_b(rst_b), .link(link),
    .sample_word(sample_word), .powered_down(powered_down),
    .sample_taken(sample_taken));
  adc_host i_adc_host (.clock(clock), .rst_b(rst_b), .link(link),
    .sync_req(sync_req), .cs_mode(cs_mode), .word_valid(word_valid),
    .word_ready(word_ready), .word_data(word_data));
  adc_link_asserts i_adc_link_asserts (.clock(clock), .rst_b(rst_b),
    .sclk(link.sclk), .cs_n(link.cs_n), .sync_n(link.sync_n),
    .ready_n(link.ready_n), .sdo_oe(link.sdo_oe), .sdo(link.sdo));

  // Clock and hang guard
  always #12.5 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 70000) begin
      err_count++;
      results();
    end
  end

  // Compare and verdict
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Wait for a word, compare and pop it
  task automatic read_word(input logic [23:0] exp);
    n = 0;
    while (word_valid !== 1'b1 && n < 60000) begin
      @(posedge clock);
      n++;
    end
    check(word_valid, 24'h1);
    check(word_data, exp);
    word_ready <= 1'b1;
    @(posedge clock);
    word_ready <= 1'b0;
    @(posedge clock);
  endtask

  // Test sequence
  initial begin
    sample_word = 24'h800001;
    sync_req    = 1'b0;
    cs_mode     = 1'b1;
    word_ready  = 1'b0;
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    read_word(24'h800001);
    $display("select read done");
    cs_mode     <= 1'b0;
    sample_word <= 24'h7FFFFE;
    read_word(24'h7FFFFE);
    read_word(24'h7FFFFE);
    $display("three-wire read done");
    cs_mode     <= 1'b1;
    sample_word <= 24'hA5C31E;
    repeat (2600) @(posedge clock);
    check(word_valid, 24'h1);
    read_word(24'hA5C31E);
    read_word(24'hA5C31E);
    $display("stall read done");
    @(posedge link.ready_n);
    @(posedge clock);
    sync_req <= 1'b1;
    @(posedge clock);
    sync_req <= 1'b0;
    repeat (130) @(posedge clock);
    check(powered_down, 24'h1);
    n = 0;
    while (link.sync_n !== 1'b1 && n < 500) begin
      @(posedge clock);
      n++;
    end
    n = 0;
    while (sample_taken !== 1'b1 && n < 500) begin
      @(posedge clock);
      n++;
    end
    check(n inside {[150:250]}, 24'h1);
    check(powered_down, 24'h0);
    n = 0;
    @(posedge clock);
    while (sample_taken !== 1'b1 && n < 500) begin
      @(posedge clock);
      n++;
    end
    check(24'(n + 1), 24'h50);
    repeat (2000) @(posedge clock);
    check(link.ready_n, 24'h1);
    $display("sync test done");
    results();
  end
endmodule

`default_nettype wire
